// *** hdl/sem_host.sv ***
// Contract
// - write zero requests, one releases
// - deselect between successive polling reads
// - write zero first, then read back
// - failed request: keep reading or withdraw
// - write one everywhere at power-up
// - hold array select high for flags
`timescale 1ns/1ps
module sem_host import sem_pkg::*; (
	input wire logic clk, // system clock
	input wire logic reset_n, // async reset, low active
	input wire logic cmd_valid, // command offered
	output logic cmd_ready, // command taken when high
	input wire cmd_t cmd_op, // operation
	input wire logic [IDX_W-1:0] cmd_idx, // flag number
	input wire logic cmd_poll, // acquire: poll before giving up
	output logic rsp_valid, // one-cycle completion pulse
	output logic rsp_granted, // acquire won
	output logic rsp_flag, // flag value last read, set to one by a release
	output logic rsp_mixed, // read bits disagreed
	output logic [FLAG_COUNT-1:0] held_mask, // tokens this side owns
	output logic array_select_n, // ram array select
	output logic flag_space_select_n, // semaphore space select
	output logic out_drive_enable_n, // part output enable
	output logic write_not_read, // low writes
	output logic [ADDR_W-1:0] addr, // address lines
	output logic [DATA_W-1:0] data_out, // data to pins
	output logic data_oe_n, // low while driving data
	input wire logic [DATA_W-1:0] data_in // data from pins
);

	typedef enum logic [5:0] {
		S_INIT = 6'b000001,
		S_IDLE = 6'b000010,
		S_WR = 6'b000100,
		S_RD = 6'b001000,
		S_WITHDRAW = 6'b010000,
		S_RESP = 6'b100000
	} host_state_t;

	host_state_t state_r;
	logic rst_meta_r;
	logic rst_sync_r;
	logic issued_r;
	cmd_t op_r;
	logic [IDX_W-1:0] idx_r;
	logic poll_r;
	logic [TRY_W-1:0] tries_r;
	logic from_cmd_r;
	logic granted_r;
	logic flag_r;
	logic mixed_r;
	logic rsp_valid_r;
	logic [FLAG_COUNT-1:0] held_r;
	logic read_zero;

	sem_cycle_if cyc ();

	function automatic logic bits_agree(input logic [DATA_W-1:0] w);
		bits_agree = (w == '0) || (w == '1);
	endfunction

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			rst_meta_r <= 1'b0;
			rst_sync_r <= 1'b0;
		end else begin
			rst_meta_r <= 1'b1;
			rst_sync_r <= rst_meta_r;
		end
	end

	assign cmd_ready = (state_r == S_IDLE);
	assign rsp_valid = rsp_valid_r;
	assign rsp_granted = granted_r;
	assign rsp_flag = flag_r;
	assign rsp_mixed = mixed_r;
	assign held_mask = held_r;

	// a request goes to the pin sequencer once per access; S_INIT and a polling S_RD raise it again after each done
	assign cyc.req = (state_r == S_INIT || state_r == S_WR || state_r == S_RD ||
		state_r == S_WITHDRAW) && !issued_r;
	assign cyc.we = (state_r == S_INIT || state_r == S_WR || state_r == S_WITHDRAW);
	assign cyc.wbit = !(state_r == S_WR && op_r == CMD_ACQUIRE);
	assign cyc.idx = idx_r;
	assign read_zero = !cyc.rword[0];

	always_ff @(posedge clk or negedge rst_sync_r) begin
		if (!rst_sync_r) begin
			issued_r <= 1'b0;
		end else if (cyc.done) begin
			issued_r <= 1'b0;
		end else if (cyc.req) begin
			issued_r <= 1'b1;
		end
	end

	always_ff @(posedge clk or negedge rst_sync_r) begin
		if (!rst_sync_r) begin
			state_r <= S_INIT;
			op_r <= CMD_INIT;
			idx_r <= '0;
			poll_r <= 1'b0;
			tries_r <= '0;
			from_cmd_r <= 1'b0;
		end else begin
			case (state_r)
				S_INIT: begin
					// one per flag; the other side frees its own request latches
					if (cyc.done) begin
						if (idx_r == FLAG_LAST) begin
							state_r <= from_cmd_r ? S_RESP : S_IDLE;
						end else begin
							idx_r <= idx_r + 1'b1;
						end
					end
				end
				S_IDLE: begin
					if (cmd_valid) begin
						op_r <= cmd_op;
						idx_r <= cmd_idx;
						poll_r <= cmd_poll;
						tries_r <= '0;
						from_cmd_r <= 1'b1;
						case (cmd_op)
							CMD_TEST: state_r <= S_RD;
							CMD_INIT: begin
								idx_r <= '0;
								state_r <= S_INIT;
							end
							default: state_r <= S_WR;
						endcase
					end
				end
				S_WR: begin
					if (cyc.done) begin
						state_r <= (op_r == CMD_ACQUIRE) ? S_RD : S_RESP;
					end
				end
				S_RD: begin
					if (cyc.done) begin
						tries_r <= tries_r + 1'b1;
						if (op_r != CMD_ACQUIRE || read_zero) begin
							state_r <= S_RESP;
						end else if (poll_r && tries_r != POLL_LIMIT - 1'b1) begin
							state_r <= S_RD;
						end else begin
							state_r <= S_WITHDRAW;
						end
					end
				end
				S_WITHDRAW: begin
					// a stale request latch would hand us a token nobody uses
					if (cyc.done) begin
						state_r <= S_RESP;
					end
				end
				S_RESP: state_r <= S_IDLE;
				default: state_r <= S_IDLE;
			endcase
		end
	end

	always_ff @(posedge clk or negedge rst_sync_r) begin
		if (!rst_sync_r) begin
			held_r <= HELD_RESET;
		end else if (state_r == S_INIT && cyc.done) begin
			held_r[idx_r] <= 1'b0;
		end else if (state_r == S_RD && cyc.done && op_r == CMD_ACQUIRE && read_zero) begin
			held_r[idx_r] <= 1'b1;
		end else if (state_r == S_WR && cyc.done && op_r == CMD_RELEASE) begin
			held_r[idx_r] <= 1'b0;
		end
	end

	always_ff @(posedge clk or negedge rst_sync_r) begin
		if (!rst_sync_r) begin
			granted_r <= 1'b0;
			flag_r <= 1'b1;
			mixed_r <= 1'b0;
		end else if (state_r == S_IDLE && cmd_valid) begin
			granted_r <= 1'b0;
			mixed_r <= 1'b0;
		end else if (state_r == S_RD && cyc.done) begin
			// value was latched when output enable fell, so a write from the far side cannot tear it
			flag_r <= cyc.rword[0];
			mixed_r <= !bits_agree(cyc.rword);
			granted_r <= (op_r == CMD_ACQUIRE) && read_zero;
		end else if (state_r == S_WR && cyc.done && op_r == CMD_RELEASE) begin
			flag_r <= 1'b1;
		end
	end

	always_ff @(posedge clk or negedge rst_sync_r) begin
		if (!rst_sync_r) begin
			rsp_valid_r <= 1'b0;
		end else begin
			rsp_valid_r <= (state_r == S_RESP);
		end
	end

	sem_pin_cycle pins (
		.clk(clk),
		.rst_n(rst_sync_r),
		.cyc(cyc),
		.array_select_n(array_select_n),
		.flag_space_select_n(flag_space_select_n),
		.out_drive_enable_n(out_drive_enable_n),
		.write_not_read(write_not_read),
		.addr(addr),
		.data_out(data_out),
		.data_oe_n(data_oe_n),
		.data_in(data_in)
	);

endmodule

// *** hdl/sem_pkg.sv ***
package sem_pkg;

	localparam int CLK_MHZ = 125;
	localparam int FLAG_COUNT = 8;
	localparam int IDX_W = 3;
	localparam int DATA_W = 8;
	localparam int ADDR_W = 15;
	localparam int CNT_W = 4;
	localparam int TRY_W = 5;

	// pin timing towards the asynchronous part, in ns
	localparam int ADDR_SETUP_NS = 10;
	localparam int WRITE_PULSE_NS = 40;
	localparam int READ_ACCESS_NS = 60;
	localparam int DESELECT_NS = 20;

	localparam int ADDR_SETUP_CYC = ((ADDR_SETUP_NS * CLK_MHZ + 999) / 1000 < 1) ? 1 :
		(ADDR_SETUP_NS * CLK_MHZ + 999) / 1000;
	localparam int WRITE_PULSE_CYC = ((WRITE_PULSE_NS * CLK_MHZ + 999) / 1000 < 1) ? 1 :
		(WRITE_PULSE_NS * CLK_MHZ + 999) / 1000;
	localparam int READ_ACCESS_CYC = ((READ_ACCESS_NS * CLK_MHZ + 999) / 1000 < 1) ? 1 :
		(READ_ACCESS_NS * CLK_MHZ + 999) / 1000;
	localparam int DESELECT_CYC = ((DESELECT_NS * CLK_MHZ + 999) / 1000 < 1) ? 1 :
		(DESELECT_NS * CLK_MHZ + 999) / 1000;

	localparam logic [CNT_W-1:0] SETUP_LAST = CNT_W'(ADDR_SETUP_CYC - 1);
	localparam logic [CNT_W-1:0] WRITE_LAST = CNT_W'(WRITE_PULSE_CYC - 1);
	localparam logic [CNT_W-1:0] READ_LAST = CNT_W'(READ_ACCESS_CYC - 1);
	localparam logic [CNT_W-1:0] GAP_LAST = CNT_W'(DESELECT_CYC - 1);

	// reads made while polling before the pending request is withdrawn
	localparam logic [TRY_W-1:0] POLL_LIMIT = 5'h10;
	localparam logic [IDX_W-1:0] FLAG_LAST = 3'h7;
	localparam logic [FLAG_COUNT-1:0] HELD_RESET = 8'h00;

	typedef enum logic [1:0] {
		CMD_TEST = 2'h0,
		CMD_ACQUIRE = 2'h1,
		CMD_RELEASE = 2'h2,
		CMD_INIT = 2'h3
	} cmd_t;

endpackage

// *** hdl/sem_cycle_if.sv ***
`timescale 1ns/1ps
interface sem_cycle_if;
	import sem_pkg::*;
	logic req;
	logic we;
	logic [IDX_W-1:0] idx;
	logic wbit;
	logic done;
	logic [DATA_W-1:0] rword;

	modport master (output req, output we, output idx, output wbit, input done, input rword);
	modport slave (input req, input we, input idx, input wbit, output done, output rword);
endinterface

// *** hdl/sem_pin_cycle.sv ***
`timescale 1ns/1ps
module sem_pin_cycle import sem_pkg::*; (
	input wire logic clk, // system clock
	input wire logic rst_n, // synchronised reset
	sem_cycle_if.slave cyc, // one access per request
	output logic array_select_n, // ram array select
	output logic flag_space_select_n, // semaphore space select
	output logic out_drive_enable_n, // part output enable
	output logic write_not_read, // low writes
	output logic [ADDR_W-1:0] addr, // address lines
	output logic [DATA_W-1:0] data_out, // data to pins
	output logic data_oe_n, // low while driving data
	input wire logic [DATA_W-1:0] data_in // data from pins
);

	typedef enum logic [3:0] {
		P_IDLE = 4'b0001,
		P_SETUP = 4'b0010,
		P_PULSE = 4'b0100,
		P_GAP = 4'b1000
	} pin_state_t;

	pin_state_t state_r;
	logic [CNT_W-1:0] cnt_r;
	logic we_r;
	logic [DATA_W-1:0] rword_r;

	assign cyc.done = (state_r == P_GAP) && (cnt_r == '0);
	assign cyc.rword = rword_r;
	assign array_select_n = 1'b1;

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			state_r <= P_IDLE;
			cnt_r <= '0;
			we_r <= 1'b0;
		end else begin
			case (state_r)
				P_IDLE: begin
					if (cyc.req) begin
						we_r <= cyc.we;
						cnt_r <= SETUP_LAST;
						state_r <= P_SETUP;
					end
				end
				P_SETUP: begin
					if (cnt_r == '0) begin
						cnt_r <= we_r ? WRITE_LAST : READ_LAST;
						state_r <= P_PULSE;
					end else begin
						cnt_r <= cnt_r - 1'b1;
					end
				end
				P_PULSE: begin
					if (cnt_r == '0) begin
						cnt_r <= GAP_LAST;
						state_r <= P_GAP;
					end else begin
						cnt_r <= cnt_r - 1'b1;
					end
				end
				P_GAP: begin
					if (cnt_r == '0) begin
						state_r <= P_IDLE;
					end else begin
						cnt_r <= cnt_r - 1'b1;
					end
				end
				default: state_r <= P_IDLE;
			endcase
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			flag_space_select_n <= 1'b1;
			out_drive_enable_n <= 1'b1;
			write_not_read <= 1'b1;
			addr <= '0;
			data_out <= '0;
			data_oe_n <= 1'b1;
		end else begin
			if (state_r == P_IDLE && cyc.req) begin
				flag_space_select_n <= 1'b0;
				addr <= {{(ADDR_W-IDX_W){1'b0}}, cyc.idx};
				data_out <= {DATA_W{cyc.wbit}};
				data_oe_n <= !cyc.we;
			end
			if (state_r == P_SETUP && cnt_r == '0) begin
				write_not_read <= !we_r;
				out_drive_enable_n <= we_r;
			end
			// deselect every access so the part re-latches its flag on the next read
			if (state_r == P_PULSE && cnt_r == '0) begin
				flag_space_select_n <= 1'b1;
				out_drive_enable_n <= 1'b1;
				write_not_read <= 1'b1;
			end
			// data held past the write edge for hold time
			if (cyc.done) begin
				data_oe_n <= 1'b1;
			end
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			rword_r <= '0;
		end else if (state_r == P_PULSE && cnt_r == '0 && !we_r) begin
			rword_r <= data_in;
		end
	end

endmodule

// *** verification/sem_host_props.sv ***
`timescale 1ns/1ps
module sem_host_props import sem_pkg::*; (
	input wire logic clk, // clock
	input wire logic reset_n, // reset
	input wire logic rsp_valid, // done
	input wire logic rsp_granted, // won
	input wire logic rsp_flag, // flag
	input wire logic array_select_n, // ram sel
	input wire logic flag_space_select_n, // flag sel
	input wire logic out_drive_enable_n, // oe
	input wire logic write_not_read, // we
	input wire logic [ADDR_W-1:0] addr, // address
	input wire logic [DATA_W-1:0] data_out, // data
	input wire logic data_oe_n // drive
);
	default clocking @(posedge clk); endclocking
	default disable iff (!reset_n);
	a_ram_unused: assert property (
		array_select_n) else $error("ram array selected");
	a_write_framed: assert property (
		!write_not_read |-> !data_oe_n && !flag_space_select_n && out_drive_enable_n)
		else $error("write strobe outside a flag write");
	a_write_value: assert property (
		!data_oe_n |-> data_out == 8'h00 || data_out == 8'hff)
		else $error("write data not replicated");
	a_low_index: assert property (
		!flag_space_select_n |-> addr[ADDR_W-1:IDX_W] == '0)
		else $error("upper address bits set");
	a_strobe_setup: assert property (
		$fell(out_drive_enable_n) || $fell(write_not_read) |-> $past(flag_space_select_n, 2) == 1'b0)
		else $error("strobe without select setup");
	a_read_hold: assert property (
		$fell(out_drive_enable_n) |-> !out_drive_enable_n [*5] ##[1:4] out_drive_enable_n)
		else $error("read pulse length wrong");
	a_poll_gap: assert property (
		$rose(flag_space_select_n) |-> flag_space_select_n [*3])
		else $error("deselect gap too short");
	a_won_reads_zero: assert property (
		rsp_valid && rsp_granted |-> !rsp_flag)
		else $error("grant without zero read");
endmodule
bind sem_host sem_host_props i_props (.clk, .reset_n, .rsp_valid, .rsp_granted, .rsp_flag,
	.array_select_n, .flag_space_select_n, .out_drive_enable_n, .write_not_read, .addr,
	.data_out, .data_oe_n);

// *** verification/sem_flag_part.sv ***
`timescale 1ns/1ps
module sem_flag_part import sem_pkg::*; (
	input wire logic l_arr_n, // left ram sel
	input wire logic l_sel_n, // left flag sel
	input wire logic l_oe_n, // left oe
	input wire logic l_wr_n, // left write
	input wire logic [ADDR_W-1:0] l_addr, // left addr
	input wire logic [DATA_W-1:0] l_d, // left wdata
	output logic [DATA_W-1:0] l_q, // left rdata
	input wire logic r_sel_n, // right flag sel
	input wire logic r_oe_n, // right oe
	input wire logic r_wr_n, // right write
	input wire logic [IDX_W-1:0] r_idx, // right index
	input wire logic r_d0, // right wdata
	output logic [DATA_W-1:0] r_q // right rdata
);
	// power-up contents are arbitrary: some tokens held, some requests pending
	logic [FLAG_COUNT-1:0] req_l = 8'hbd, req_r = 8'hdb;
	logic [FLAG_COUNT-1:0] own_l = 8'h42, own_r = 8'h24;
	logic lat_l = 1'b1, lat_r = 1'b1;
	// writes apply one at a time, so a tie goes to whichever runs first
	task automatic put(input logic rt, input logic [IDX_W-1:0] i, input logic v);
		if (rt) req_r[i] = v;
		else req_l[i] = v;
		if (own_l[i] && req_l[i]) own_l[i] = 1'b0;
		if (own_r[i] && req_r[i]) own_r[i] = 1'b0;
		if (!own_l[i] && !own_r[i] && !req_l[i]) own_l[i] = 1'b1;
		else if (!own_l[i] && !own_r[i] && !req_r[i]) own_r[i] = 1'b1;
	endtask
	always @(negedge l_wr_n) begin
		if (!l_sel_n && l_arr_n) begin
			put(1'b0, l_addr[IDX_W-1:0], l_d[0]);
		end
	end
	always @(negedge r_wr_n) begin
		if (!r_sel_n) begin
			put(1'b1, r_idx, r_d0);
		end
	end
	always @(negedge l_oe_n or negedge l_sel_n) begin
		if (!l_oe_n && !l_sel_n) begin
			lat_l = !own_l[l_addr[IDX_W-1:0]];
		end
	end
	always @(negedge r_oe_n or negedge r_sel_n) begin
		if (!r_oe_n && !r_sel_n) begin
			lat_r = !own_r[r_idx];
		end
	end
	// no pull-ups: a released bus shows the inverse
	assign l_q = (!l_sel_n && !l_oe_n) ? {DATA_W{lat_l}} : {DATA_W{!lat_l}};
	assign r_q = (!r_sel_n && !r_oe_n) ? {DATA_W{lat_r}} : {DATA_W{!lat_r}};
endmodule

// *** verification/testbench.sv ***
`timescale 1ns/1ps
module testbench import sem_pkg::*;;
	logic clk = 1'b0, reset_n = 1'b0, cmd_valid = 1'b0, cmd_poll = 1'b0;
	cmd_t cmd_op = CMD_TEST;
	logic [IDX_W-1:0] cmd_idx = 3'h0, r_idx = 3'h0;
	logic r_sel_n = 1'b1, r_oe_n = 1'b1, r_wr_n = 1'b1, r_d0 = 1'b1;
	logic cmd_ready, rsp_valid, rsp_granted, rsp_flag, rsp_mixed, data_oe_n;
	logic array_select_n, flag_space_select_n, out_drive_enable_n, write_not_read;
	logic [FLAG_COUNT-1:0] held_mask;
	logic [ADDR_W-1:0] addr;
	logic [DATA_W-1:0] data_out, data_in, r_q;
	int bad_count = 0, checks = 0;
	always #4 clk = ~clk;
	sem_host i_dut (.clk, .reset_n, .cmd_valid, .cmd_ready, .cmd_op, .cmd_idx, .cmd_poll,
		.rsp_valid, .rsp_granted, .rsp_flag, .rsp_mixed, .held_mask, .array_select_n,
		.flag_space_select_n, .out_drive_enable_n, .write_not_read, .addr, .data_out,
		.data_oe_n, .data_in);
	sem_flag_part i_part (.l_arr_n(array_select_n), .l_sel_n(flag_space_select_n),
		.l_oe_n(out_drive_enable_n), .l_wr_n(write_not_read), .l_addr(addr), .l_d(data_out),
		.l_q(data_in), .r_sel_n, .r_oe_n, .r_wr_n, .r_idx, .r_d0, .r_q);
	task automatic chk(input string n, input logic [7:0] got, input logic [7:0] exp);
		checks++;
		if (got !== exp) begin
			bad_count++;
			$display("[ERR] %s expected %h seen %h", n, exp, got);
		end
	endtask
	task automatic test_done;
		$display("checks %0d mismatches %0d", checks, bad_count);
		if (bad_count == 0 && checks > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask
	task automatic cmd(input cmd_t op, input logic [IDX_W-1:0] i, input logic p);
		int n;
		n = 0;
		@(negedge clk);
		while (cmd_ready !== 1'b1 && n < 400) begin
			@(negedge clk);
			n++;
		end
		cmd_valid = 1'b1;
		cmd_op = op;
		cmd_idx = i;
		cmd_poll = p;
		@(negedge clk);
		cmd_valid = 1'b0;
		chk("busy", {7'h0, cmd_ready}, 8'h00);
		while (rsp_valid !== 1'b1 && n < 800) begin
			@(negedge clk);
			n++;
		end
		chk("rsp_valid", {7'h0, rsp_valid}, 8'h01);
	endtask
	// the far processor, strobes moved on falling edges
	task automatic r_wr(input logic [IDX_W-1:0] i, input logic v);
		@(negedge clk);
		r_idx = i;
		r_d0 = v;
		r_sel_n = 1'b0;
		@(negedge clk);
		r_wr_n = 1'b0;
		@(negedge clk);
		r_wr_n = 1'b1;
		@(negedge clk);
		r_sel_n = 1'b1;
	endtask
	task automatic r_rd(input logic [IDX_W-1:0] i, input logic [7:0] exp);
		@(negedge clk);
		r_idx = i;
		r_sel_n = 1'b0;
		r_oe_n = 1'b0;
		@(negedge clk);
		chk("far read", r_q, exp);
		r_oe_n = 1'b1;
		r_sel_n = 1'b1;
	endtask
	task automatic t_start;
		chk("held after init", held_mask, 8'h00);
		for (int i = 0; i < FLAG_COUNT; i++) begin
			r_wr(IDX_W'(i), 1'b1);
		end
		for (int i = 0; i < FLAG_COUNT; i++) begin
			cmd(CMD_TEST, IDX_W'(i), 1'b0);
			chk("free flag", {7'h0, rsp_flag}, 8'h01);
			chk("mixed", {7'h0, rsp_mixed}, 8'h00);
		end
		$display("start test done");
	endtask
	task automatic t_grab;
		cmd(CMD_ACQUIRE, 3'h3, 1'b0);
		chk("granted", {7'h0, rsp_granted}, 8'h01);
		chk("held", held_mask, 8'h08);
		r_rd(3'h3, 8'hff);
		r_wr(3'h5, 1'b0);
		cmd(CMD_ACQUIRE, 3'h5, 1'b0);
		chk("refused", {7'h0, rsp_granted}, 8'h00);
		chk("held", held_mask, 8'h08);
		r_wr(3'h5, 1'b1);
		// a request left pending would pass the token to this side
		cmd(CMD_TEST, 3'h5, 1'b0);
		chk("withdrawn", {7'h0, rsp_flag}, 8'h01);
		r_rd(3'h5, 8'hff);
		$display("grab test done");
	endtask
	task automatic t_poll;
		r_wr(3'h6, 1'b0);
		fork
			cmd(CMD_ACQUIRE, 3'h6, 1'b1);
			begin
				repeat (60) @(negedge clk);
				r_wr(3'h6, 1'b1);
			end
		join
		chk("poll won", {7'h0, rsp_granted}, 8'h01);
		chk("held", held_mask, 8'h48);
		r_rd(3'h6, 8'hff);
		$display("poll test done");
	endtask
	task automatic t_release;
		cmd(CMD_RELEASE, 3'h3, 1'b0);
		chk("release flag", {7'h0, rsp_flag}, 8'h01);
		chk("held", held_mask, 8'h40);
		r_wr(3'h3, 1'b0);
		r_rd(3'h3, 8'h00);
		cmd(CMD_TEST, 3'h3, 1'b0);
		chk("other owns", {7'h0, rsp_flag}, 8'h01);
		r_wr(3'h3, 1'b1);
		cmd(CMD_INIT, 3'h0, 1'b0);
		chk("held", held_mask, 8'h00);
		r_rd(3'h6, 8'hff);
		$display("release test done");
	endtask
	initial begin
		#40000;
		bad_count++;
		$display("watchdog expired");
		test_done;
	end
	initial begin
		repeat (16) @(posedge clk);
		@(negedge clk);
		reset_n = 1'b1;
		t_start;
		t_grab;
		t_poll;
		t_release;
		test_done;
	end
endmodule
